// *** hw/adc_serial_result_port.sv ***
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
// Contract
// - each result is one 32-bit serial word
// - three status bits, 24 result bits, 5 sub-lsbs
// - bit 31 is done flag, low when finished
// - bit 30 is filler, always low
// - bit 29 polarity, high for zero or positive
// - bits 29,28 both high/low flag range faults
// - bits 28..5 result, bits 4..0 sub-lsbs
// - zero, minus one, over, under codes fixed
// - out-of-range inputs clamp to limit codes
// - select high: output floats, clock ignored
// - select low in convert/sleep shows done flag
// - output changes on falling serial clock edge
// - flag on first rise, bit 30 after first fall
// - bit 0 after 31st fall, host latches 32nd rise
// - 32nd fall drives high, starts new conversion
// - sleep until rising clock with select low
// - select rising during output aborts, converts
// - strap low external clock, high internal clock
// - output state ends at 32 bits or deselect
// - result held static while sleeping deselected
module adc_serial_result_port (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        cs_b,
   input  wire logic        sclk_in,
   output logic             sclk_out,
   output logic             sclk_oe_b,
   input  wire logic        clock_source_strap,
   output logic             serial_out,
   output logic             serial_out_oe_b
);

   result_port_pkg::port_state_s s;
   result_port_pkg::port_state_s next_s;

   logic       cs_low;
   logic       cs_rise;
   logic       ext_rise;
   logic       ext_fall;
   logic       run_int;
   logic [7:0] half_m1;
   logic       tick;
   logic       rise_evt;
   logic       fall_evt;
   logic       addr_ok;
   logic [5:0] addr_idx;

   // clamp and pack one conversion into the serial word
   function automatic logic [31:0] encode(input logic [31:0] v);
      logic signed [31:0] c;
      c = $signed(v);
      if (c > result_port_pkg::POS_CLAMP) begin
         c = result_port_pkg::POS_CLAMP;
      end else if (c < result_port_pkg::NEG_CLAMP) begin
         c = result_port_pkg::NEG_CLAMP;
      end
      // done low, filler low, polarity, result and sub-lsbs
      encode = {1'b0, 1'b0, ~c[31], c[28:0]};
   endfunction : encode

   // synchronised pin levels and their edges
   assign cs_low   = ~s.cs_s2;
   assign cs_rise  = s.cs_s2 & ~s.cs_d;
   assign ext_rise = s.sclk_s2 & ~s.sclk_d;
   assign ext_fall = ~s.sclk_s2 & s.sclk_d;

   // internal clock divider runs only while selected and not converting
   assign run_int = s.strap_s2 & cs_low &
                    (s.st != result_port_pkg::ST_CONVERT);
   assign half_m1 = (s.sclk_half == 8'h00) ? 8'h00 : s.sclk_half - 8'h01;
   assign tick    = run_int & (s.div_cnt >= half_m1);

   // clock edges seen by the shifter; select high blocks them all
   assign rise_evt = cs_low & (s.strap_s2 ? (tick & ~s.int_sclk)
                                          : ext_rise);
   assign fall_evt = cs_low & (s.strap_s2 ? (tick & s.int_sclk)
                                          : ext_fall);

   // bus address decode; anything above the map reads zero
   assign addr_ok  = (haddr[31:8] == 24'h00_0000);
   assign addr_idx = addr_ok ? haddr[7:2] : 6'h3f;

   // next state of the whole port
   always_comb begin
      next_s = s;

      // two-flop synchronisers plus one edge stage
      next_s.cs_s1    = cs_b;
      next_s.cs_s2    = s.cs_s1;
      next_s.cs_d     = s.cs_s2;
      next_s.sclk_s1  = sclk_in;
      next_s.sclk_s2  = s.sclk_s1;
      next_s.sclk_d   = s.sclk_s2;
      next_s.strap_s1 = clock_source_strap;
      next_s.strap_s2 = s.strap_s1;

      // internal serial clock generator
      if (!run_int) begin
         next_s.div_cnt  = 8'h00;
         next_s.int_sclk = 1'b0;
      end else if (tick) begin
         next_s.div_cnt  = 8'h00;
         next_s.int_sclk = ~s.int_sclk;
      end else begin
         next_s.div_cnt  = s.div_cnt + 8'h01;
      end

      // converter cycle
      case (s.st)
         result_port_pkg::ST_CONVERT: begin
            if ((s.conv_cnt + 16'h0001) >= s.conv_time) begin
               next_s.shreg      = encode(s.sample);
               next_s.conv_cnt   = 16'h0000;
               next_s.conv_count = s.conv_count + 16'h0001;
               next_s.st         = result_port_pkg::ST_SLEEP;
            end else begin
               next_s.conv_cnt   = s.conv_cnt + 16'h0001;
            end
         end
         result_port_pkg::ST_SLEEP: begin
            // result stays in the shifter until a selected rise
            if (rise_evt) begin
               next_s.st       = result_port_pkg::ST_OUTPUT;
               next_s.fall_cnt = 6'h00;
            end
         end
         result_port_pkg::ST_OUTPUT: begin
            if (cs_rise) begin
               next_s.st       = result_port_pkg::ST_CONVERT;
               next_s.conv_cnt = 16'h0000;
            end else if (fall_evt) begin
               if (s.fall_cnt == result_port_pkg::LAST_FALL) begin
                  next_s.st       = result_port_pkg::ST_CONVERT;
                  next_s.conv_cnt = 16'h0000;
               end else begin
                  next_s.shreg    = {s.shreg[30:0], 1'b0};
                  next_s.fall_cnt = s.fall_cnt + 6'h01;
               end
            end
         end
         default: begin
            next_s.st       = result_port_pkg::ST_CONVERT;
            next_s.conv_cnt = 16'h0000;
         end
      endcase

      // serial pin: busy flag while converting, low in sleep, data else
      if (next_s.st == result_port_pkg::ST_OUTPUT) begin
         next_s.serial_out = next_s.shreg[31];
      end else begin
         next_s.serial_out =
            (next_s.st == result_port_pkg::ST_CONVERT);
      end
      next_s.serial_out_oe_b = s.cs_s2;
      next_s.sclk_oe_b       = ~s.strap_s2;

      // bus data phase: writes land here
      next_s.hreadyout = 1'b1;
      next_s.hresp     = 1'b0;
      if (s.dp_write) begin
         case (s.dp_addr)
            result_port_pkg::CONFIG_OFS[7:2]: begin
               next_s.conv_time = hwdata[result_port_pkg::CONV_TIME_LSB +: 16];
               next_s.sclk_half = hwdata[result_port_pkg::SCLK_HALF_LSB +: 8];
            end
            result_port_pkg::SAMPLE_OFS[7:2]: begin
               next_s.sample = hwdata;
            end
            default: begin
            end
         endcase
      end

      // bus address phase: capture request, prepare read data
      next_s.dp_write = hsel & htrans[1] & hready & hwrite;
      next_s.dp_addr  = addr_idx;
      next_s.hrdata   = s.hrdata;
      if (hsel & htrans[1] & hready & ~hwrite) begin
         next_s.hrdata = 32'h0000_0000;
         case (addr_idx)
            result_port_pkg::CONFIG_OFS[7:2]: begin
               next_s.hrdata[result_port_pkg::CONV_TIME_LSB +: 16] =
                  next_s.conv_time;
               next_s.hrdata[result_port_pkg::SCLK_HALF_LSB +: 8] =
                  next_s.sclk_half;
            end
            result_port_pkg::SAMPLE_OFS[7:2]: begin
               next_s.hrdata = next_s.sample;
            end
            result_port_pkg::STATUS_OFS[7:2]: begin
               next_s.hrdata[result_port_pkg::ST_STATE_LSB +: 2] = s.st;
               next_s.hrdata[result_port_pkg::ST_FALLS_LSB +: 6] = s.fall_cnt;
               next_s.hrdata[result_port_pkg::ST_EOC_BIT] =
                  (s.st == result_port_pkg::ST_CONVERT);
               next_s.hrdata[result_port_pkg::ST_SEL_BIT]   = cs_low;
               next_s.hrdata[result_port_pkg::ST_STRAP_BIT] = s.strap_s2;
               next_s.hrdata[result_port_pkg::ST_COUNT_LSB +: 16] =
                  s.conv_count;
            end
            default: begin
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s                 <= '0;
         s.st              <= result_port_pkg::ST_CONVERT;
         s.cs_s1           <= 1'b1;
         s.cs_s2           <= 1'b1;
         s.cs_d            <= 1'b1;
         s.conv_time       <= result_port_pkg::CONV_TIME_RST;
         s.sclk_half       <= result_port_pkg::SCLK_HALF_RST;
         s.sample          <= result_port_pkg::SAMPLE_RST;
         s.serial_out_oe_b <= 1'b1;
         s.sclk_oe_b       <= 1'b1;
         s.hreadyout       <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign hreadyout       = s.hreadyout;
   assign hrdata          = s.hrdata;
   assign hresp           = s.hresp;
   assign sclk_out        = s.int_sclk;
   assign sclk_oe_b       = s.sclk_oe_b;
   assign serial_out      = s.serial_out;
   assign serial_out_oe_b = s.serial_out_oe_b;

   // checks on the serial side
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   AST_DESELECT_FLOATS: assert property (
      s.cs_s2 |=> serial_out_oe_b)
      else $error("serial output driven while deselected");

   AST_BUSY_FLAG_HIGH: assert property (
      (!serial_out_oe_b && s.st == result_port_pkg::ST_CONVERT)
         |-> serial_out)
      else $error("done flag not high during conversion");

   AST_SLEEP_FLAG_LOW: assert property (
      (!serial_out_oe_b && s.st == result_port_pkg::ST_SLEEP)
         |-> !serial_out)
      else $error("done flag not low in sleep");

   AST_FILLER_LOW: assert property (
      (s.st == result_port_pkg::ST_OUTPUT && s.fall_cnt == 6'h01)
         |-> !serial_out)
      else $error("filler bit not low");

   AST_LAST_FALL_RESTARTS: assert property (
      (s.st == result_port_pkg::ST_OUTPUT && fall_evt && !cs_rise &&
       s.fall_cnt == result_port_pkg::LAST_FALL)
         |=> (s.st == result_port_pkg::ST_CONVERT) && serial_out)
      else $error("32nd fall did not start a conversion");

   AST_ABORT: assert property (
      (s.st == result_port_pkg::ST_OUTPUT && cs_rise)
         |=> s.st == result_port_pkg::ST_CONVERT ##1 serial_out_oe_b)
      else $error("deselect did not abort the transfer");

   AST_WAKE_ON_RISE: assert property (
      (s.st == result_port_pkg::ST_SLEEP ##1
       s.st == result_port_pkg::ST_OUTPUT) |-> $past(rise_evt))
      else $error("left sleep without a selected rise");

   AST_SHIFT_ON_FALL: assert property (
      (s.st == result_port_pkg::ST_OUTPUT && fall_evt && !cs_rise &&
       s.fall_cnt < result_port_pkg::LAST_FALL)
         |=> serial_out == $past(s.shreg[30]))
      else $error("wrong bit after falling edge");

   AST_CLAMP_OVER: assert property (
      ($rose(s.st == result_port_pkg::ST_SLEEP) &&
       $signed($past(s.sample)) > result_port_pkg::POS_CLAMP)
         |-> s.shreg[29:28] == 2'b11 && s.shreg[27:0] == 28'h000_0000)
      else $error("overrange not clamped");

   AST_CLAMP_UNDER: assert property (
      ($rose(s.st == result_port_pkg::ST_SLEEP) &&
       $signed($past(s.sample)) < result_port_pkg::NEG_CLAMP)
         |-> s.shreg[29:28] == 2'b00 && s.shreg[27:0] == 28'hfff_ffff)
      else $error("underrange not clamped");

   AST_POLARITY: assert property (
      $rose(s.st == result_port_pkg::ST_SLEEP)
         |-> s.shreg[29] == !$past(s.sample[31]) && !s.shreg[31])
      else $error("polarity or done bit wrong");

   AST_STRAP_DRIVES: assert property (
      s.strap_s2 |=> !sclk_oe_b)
      else $error("internal clock mode not driving clock");

   AST_SLEEP_HOLDS: assert property (
      s.st == result_port_pkg::ST_SLEEP |=> $stable(s.shreg))
      else $error("result changed while sleeping");

   AST_FIRST_BIT_DONE: assert property (
      (s.st == result_port_pkg::ST_SLEEP && rise_evt)
         |=> s.st == result_port_pkg::ST_OUTPUT && !serial_out)
      else $error("first rise did not show the done bit");

   AST_WORD_BOUND: assert property (
      s.st == result_port_pkg::ST_OUTPUT
         |-> s.fall_cnt <= result_port_pkg::LAST_FALL)
      else $error("more than 32 bits in one word");

   AST_EXT_CLOCK_IDLE: assert property (
      !s.strap_s2 |=> !sclk_out)
      else $error("internal clock running in external mode");

   COV_WAKE_FROM_SLEEP: cover property (
      s.st == result_port_pkg::ST_SLEEP && rise_evt);
   COV_FULL_WORD: cover property (
      s.st == result_port_pkg::ST_OUTPUT && fall_evt &&
      s.fall_cnt == result_port_pkg::LAST_FALL);
   COV_ABORT: cover property (
      s.st == result_port_pkg::ST_OUTPUT && cs_rise);
   COV_OVERRANGE: cover property (
      $rose(s.st == result_port_pkg::ST_SLEEP) && s.shreg[29:28] == 2'b11);
   COV_INTERNAL_FRAME: cover property (
      s.strap_s2 && s.st == result_port_pkg::ST_OUTPUT && fall_evt);

endmodule : adc_serial_result_port

// *** inc/result_port_pkg.sv ***
package result_port_pkg;

   // converter cycle states
   typedef enum logic [1:0] {
      ST_CONVERT,
      ST_SLEEP,
      ST_OUTPUT
   } conv_state_e;

   // register byte offsets on the bus
   localparam logic [7:0]  CONFIG_OFS      = 8'h00;
   localparam logic [7:0]  SAMPLE_OFS      = 8'h04;
   localparam logic [7:0]  STATUS_OFS      = 8'h08;

   // config field positions
   localparam int          CONV_TIME_LSB   = 0;
   localparam int          SCLK_HALF_LSB   = 16;

   // status field positions
   localparam int          ST_STATE_LSB    = 0;
   localparam int          ST_FALLS_LSB    = 2;
   localparam int          ST_EOC_BIT      = 8;
   localparam int          ST_SEL_BIT      = 9;
   localparam int          ST_STRAP_BIT    = 10;
   localparam int          ST_COUNT_LSB    = 16;

   // values after reset
   localparam logic [15:0] CONV_TIME_RST   = 16'h0100;
   localparam logic [7:0]  SCLK_HALF_RST   = 8'h04;
   localparam logic [31:0] SAMPLE_RST      = 32'h0000_0000;

   // word layout
   localparam int          WORD_BITS       = 32;
   localparam logic [5:0]  LAST_FALL       = 6'h1f;

   // clamp limits in sub-lsb units (one lsb is 32 units)
   localparam logic signed [31:0] POS_CLAMP = 32'sh1000_0000;
   localparam logic signed [31:0] NEG_CLAMP = 32'shefff_ffff;

   // whole state of the port
   typedef struct packed {
      conv_state_e  st;
      logic         cs_s1;
      logic         cs_s2;
      logic         cs_d;
      logic         sclk_s1;
      logic         sclk_s2;
      logic         sclk_d;
      logic         strap_s1;
      logic         strap_s2;
      logic [15:0]  conv_cnt;
      logic [15:0]  conv_time;
      logic [7:0]   sclk_half;
      logic [7:0]   div_cnt;
      logic         int_sclk;
      logic [31:0]  sample;
      logic [31:0]  shreg;
      logic [5:0]   fall_cnt;
      logic [15:0]  conv_count;
      logic         serial_out;
      logic         serial_out_oe_b;
      logic         sclk_oe_b;
      logic         dp_write;
      logic [5:0]   dp_addr;
      logic         hreadyout;
      logic [31:0]  hrdata;
      logic         hresp;
   } port_state_s;

endpackage : result_port_pkg

// *** sim/host_reader.sv ***
`timescale 1ns/100ps
module host_reader (
   input  wire logic        clock,
   input  wire logic        sclk_wire,
   input  wire logic        serial_wire,
   output logic             cs_b,
   output logic             sclk_host,
   output logic [31:0]      word,
   output logic [5:0]       bits
);
   // deselected, clock parked low
   initial begin
      cs_b = 1'b1;
      sclk_host = 1'b0;
      word = 32'h0000_0000;
      bits = 6'h00;
   end

   // sample on rising edges while selected, msb first
   always @(posedge sclk_wire) begin
      if (!cs_b) begin
         word <= {word[30:0], serial_wire};
         bits <= bits + 6'h01;
      end
   end

   // select changes just after a system clock edge
   task select(input logic lvl);
      @(posedge clock);
      cs_b <= lvl;
      if (!lvl) begin
         bits <= 6'h00;
      end
   endtask : select

   // host clock runs only while clock_bits is called, also outside frames, 800 ns period
   task clock_bits(input int n);
      repeat (n) begin
         repeat (4) @(posedge clock);
         sclk_host <= 1'b1;
         repeat (4) @(posedge clock);
         sclk_host <= 1'b0;
      end
   endtask : clock_bits
endmodule : host_reader

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   logic        clock;
   logic        rst_b;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        cs_b;
   logic        sclk_host;
   logic        sclk_out;
   logic        sclk_oe_b;
   logic        strap;
   logic        serial_out;
   logic        serial_out_oe_b;
   logic        serial_last;
   logic        sclk_wire;
   logic        serial_wire;
   logic [31:0] word;
   logic [5:0]  bits;
   logic [31:0] rd;
   logic [23:0] page;
   int          err_count;
   int          comparisons;
   int          cycles;

   // shared serial clock; a floated data line shows the inverse level
   assign sclk_wire = sclk_oe_b ? sclk_host : sclk_out;
   assign serial_wire = serial_out_oe_b ? ~serial_last : serial_out;
   always @(posedge clock) begin
      if (!serial_out_oe_b) serial_last <= serial_out;
   end

   adc_serial_result_port i_dut (
      .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .cs_b(cs_b), .sclk_in(sclk_wire),
      .sclk_out(sclk_out), .sclk_oe_b(sclk_oe_b),
      .clock_source_strap(strap), .serial_out(serial_out),
      .serial_out_oe_b(serial_out_oe_b));

   host_reader i_host (
      .clock(clock), .sclk_wire(sclk_wire), .serial_wire(serial_wire),
      .cs_b(cs_b), .sclk_host(sclk_host), .word(word), .bits(bits));

   task end_of_test;
      if (err_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   // one single transfer; address held until hready, then data phase
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {page, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask : ahb

   // expected word from a signed sample in sub-lsb units
   function automatic logic [31:0] code(input logic signed [31:0] s);
      logic signed [31:0] c;
      c = s;
      if (s > 32'sh1000_0000) c = 32'sh1000_0000;
      if (s < 32'shefff_ffff) c = 32'shefff_ffff;
      return {2'b00, ~c[31], c[28:0]};
   endfunction : code

   task wait_done;
      int n;
      n = 0;
      while (serial_out !== 1'b0 && n < 3000) begin
         @(posedge clock);
         n++;
      end
   endtask : wait_done

   // whole read-out of one conversion, host or device clocking
   task frame(input logic [31:0] v, input logic intl);
      int n;
      strap <= intl;
      ahb(1'b1, result_port_pkg::SAMPLE_OFS, v);
      i_host.select(1'b0);
      repeat (8) @(posedge clock);
      check({31'h0, serial_out_oe_b}, 32'h0);
      check({31'h0, serial_out}, 32'h1);
      wait_done();
      check({31'h0, serial_out}, 32'h0);
      check({31'h0, sclk_oe_b}, {31'h0, ~intl});
      n = 0;
      if (!intl) i_host.clock_bits(32);
      while (bits < 6'd32 && n < 5000) begin
         @(posedge clock);
         n++;
      end
      check(word, code(v));
      repeat (12) @(posedge clock);
      check({31'h0, serial_out}, 32'h1);
      check({26'h0, bits}, 32'd32);
      i_host.select(1'b1);
      repeat (8) @(posedge clock);
      check({31'h0, serial_out_oe_b}, 32'h1);
   endtask : frame

   // reset values, unmapped read, write then read back
   task regs;
      ahb(1'b0, result_port_pkg::CONFIG_OFS, 32'h0);
      check(rd, 32'h0004_0100);
      ahb(1'b0, result_port_pkg::SAMPLE_OFS, 32'h0);
      check(rd, 32'h0);
      ahb(1'b0, 8'hfc, 32'h0);
      check(rd, 32'h0);
      page = 24'h00_0001;
      ahb(1'b0, result_port_pkg::CONFIG_OFS, 32'h0);
      check(rd, 32'h0);
      page = 24'h00_0000;
      ahb(1'b1, result_port_pkg::CONFIG_OFS, 32'h0003_0040);
      ahb(1'b0, result_port_pkg::CONFIG_OFS, 32'h0);
      check(rd, 32'h0003_0040);
   endtask : regs

   // reset in mid-run: outputs idle, registers back to reset values
   task reset_again;
      i_host.select(1'b0);
      rst_b <= 1'b0;
      repeat (4) @(posedge clock);
      check({30'h0, serial_out_oe_b, serial_out}, 32'h2);
      rst_b <= 1'b1;
      @(posedge clock);
      ahb(1'b0, result_port_pkg::CONFIG_OFS, 32'h0);
      check(rd, 32'h0004_0100);
      ahb(1'b0, result_port_pkg::STATUS_OFS, 32'h0);
      check(rd, 32'h0000_0300);
      check({30'h0, serial_out_oe_b, serial_out}, 32'h1);
      i_host.select(1'b1);
   endtask : reset_again

   // deselect mid-word, then clocks while deselected are ignored
   task abort_then_sleep;
      ahb(1'b1, result_port_pkg::SAMPLE_OFS, 32'h0000_1234);
      i_host.select(1'b0);
      wait_done();
      i_host.clock_bits(10);
      i_host.select(1'b1);
      repeat (8) @(posedge clock);
      ahb(1'b0, result_port_pkg::STATUS_OFS, 32'h0);
      check({30'h0, rd[1:0]}, 32'h0);
      repeat (300) @(posedge clock);
      i_host.clock_bits(3);
      ahb(1'b0, result_port_pkg::STATUS_OFS, 32'h0);
      check({30'h0, rd[1:0]}, 32'h1);
      check({31'h0, serial_out_oe_b}, 32'h1);
   endtask : abort_then_sleep

   // system clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         end_of_test();
      end
   end

   // main sequence
   initial begin
      logic [31:0] tbl [7];
      tbl = '{32'h0, 32'hffff_ffff, 32'h2000_0000, 32'h8000_0000,
              32'h1000_0000, 32'hefff_ffff, 32'h0123_4567};
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      page = 24'h00_0000;
      strap = 1'b0;
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      regs();
      foreach (tbl[i]) frame(tbl[i], 1'b0);
      frame(32'h0abc_def0, 1'b1);
      strap <= 1'b0;
      repeat (8) @(posedge clock);
      abort_then_sleep();
      reset_again();
      end_of_test();
   end
endmodule : testbench
